//--- hdl/pasrm_pkg.sv
/*
 Constants, pointer codes, reset values and the bus state type for the
 pointer addressed sensor register map.
 Assumes a single 125 MHz clock domain in the user of this package.
*/
`default_nettype none
package pasrm_pkg;
   // ***********************************
   // Pointer codes
   // ***********************************
   localparam logic [7:0] PTR_TEMP      = 8'h00;
   localparam logic [7:0] PTR_CFG       = 8'h01;
   localparam logic [7:0] PTR_LOW       = 8'h02;
   localparam logic [7:0] PTR_HIGH      = 8'h03;
   localparam logic [7:0] PTR_NV_CFG    = 8'h11;
   localparam logic [7:0] PTR_NV_LOW    = 8'h12;
   localparam logic [7:0] PTR_NV_HIGH   = 8'h13;
   // Extra command codes, values arbitrary
   localparam logic [7:0] CMD_TO_ACTIVE = 8'ha0;
   localparam logic [7:0] CMD_TO_STORED = 8'ha1;
   // ***********************************
   // Reset and factory values
   // ***********************************
   localparam logic [15:0] TEMP_RST      = 16'h0000;
   localparam logic [15:0] FACT_CFG      = 16'h0000;
   localparam logic [15:0] FACT_LOW      = 16'h4b00;
   localparam logic [15:0] FACT_HIGH     = 16'h5000;
   // ***********************************
   // Serial framing
   // ***********************************
   localparam logic [3:0] DEV_PREFIX    = 4'h9;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;
   localparam logic [1:0] DATA_BYTES    = 2'h2;
   localparam int         SYNC_W        = 5;
   localparam int         SCL_IDX       = 0;
   localparam int         SDA_IDX       = 1;
   localparam int         STRAP_LO      = 2;
   localparam logic [4:0] SYNC_RST      = 5'h03;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_PTR  = 3'h2,
      ST_WDAT = 3'h3,
      ST_ACK  = 3'h4,
      ST_RDAT = 3'h5,
      ST_MACK = 3'h6,
      ST_SKIP = 3'h7
   } pasrm_state_t;
endpackage
`default_nettype wire

//--- hdl/pasrm_regmap.sv
/*
 Pointer addressed register bank of a temperature sensor with a two-wire
 serial slave: pointer, temperature result, active and stored copies of
 configuration and limits.
 Assumes SCL/SDA/strap pins are asynchronous, the open-drain SDA wire is
 resolved outside, and converter, lock and soft reset run on CLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module pasrm_regmap (
   input  wire logic        CLK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic        SOFT_RST_IN,
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_N_OUT,
   input  wire logic [2:0]  ADDR_STRAP_IN,
   input  wire logic        REG_LOCK_IN,
   input  wire logic [15:0] TEMP_DATA_IN,
   input  wire logic        TEMP_VALID_IN,
   output logic [15:0]      CONFIG_OUT,
   output logic [15:0]      LOW_LIMIT_OUT,
   output logic [15:0]      HIGH_LIMIT_OUT,
   output logic             CONV_START_OUT,
   output logic             CMD_STROBE_OUT,
   output logic [7:0]       CMD_CODE_OUT
);
   // ***********************************
   // Pin synchronisers
   // ***********************************
   logic [pasrm_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, agree;
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         s1_q   <= pasrm_pkg::SYNC_RST;
         s2_q   <= pasrm_pkg::SYNC_RST;
         s3_q   <= pasrm_pkg::SYNC_RST;
         filt_q <= pasrm_pkg::SYNC_RST;
      end else begin
         s1_q   <= {ADDR_STRAP_IN, SDA_IN, SCL_IN};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end
   // A change counts once the second and third stages agree
   assign agree  = ~(s2_q ^ s3_q);
   assign filt_d = (filt_q & ~agree) | (s3_q & agree);

   logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
   logic [2:0] strap;
   assign sda_now   = filt_d[pasrm_pkg::SDA_IDX];
   assign strap     = filt_q[pasrm_pkg::STRAP_LO +: 3];
   assign scl_rise  = filt_d[pasrm_pkg::SCL_IDX] & ~filt_q[pasrm_pkg::SCL_IDX];
   assign scl_fall  = ~filt_d[pasrm_pkg::SCL_IDX] & filt_q[pasrm_pkg::SCL_IDX];
   assign bus_start = filt_q[pasrm_pkg::SCL_IDX] & filt_d[pasrm_pkg::SCL_IDX] &
                      filt_q[pasrm_pkg::SDA_IDX] & ~sda_now;
   assign bus_stop  = filt_q[pasrm_pkg::SCL_IDX] & filt_d[pasrm_pkg::SCL_IDX] &
                      ~filt_q[pasrm_pkg::SDA_IDX] & sda_now;

   // ***********************************
   // Register bank and bus state
   // ***********************************
   pasrm_pkg::pasrm_state_t state_q, state_d, nxt_q, nxt_d;
   logic [7:0]  ptr_q, ptr_d, sh_q, sh_d, code_q, code_d, tx;
   logic [15:0] temp_q, temp_d, cfg_q, cfg_d, low_q, low_d, high_q, high_d;
   logic [15:0] nv_cfg_q, nv_cfg_d, nv_low_q, nv_low_d, nv_high_q, nv_high_d;
   logic [15:0] rd_q, rd_d, rd_mux;
   logic [3:0]  cnt_q, cnt_d;
   logic [1:0]  wcnt_q, wcnt_d;
   logic        oe_n_q, oe_n_d, sel_q, sel_d, wok_q, wok_d, mnack_q, mnack_d;
   logic        conv_q, conv_d, cmd_q, cmd_d, ack, reading, ptr_ok, is_cmd;

   assign reading = (state_q == pasrm_pkg::ST_RDAT) || (state_q == pasrm_pkg::ST_MACK);
   assign ptr_ok  = (sh_q == pasrm_pkg::PTR_TEMP) || (sh_q == pasrm_pkg::PTR_CFG) ||
                    (sh_q == pasrm_pkg::PTR_LOW) || (sh_q == pasrm_pkg::PTR_HIGH) ||
                    (sh_q == pasrm_pkg::PTR_NV_CFG) || (sh_q == pasrm_pkg::PTR_NV_LOW) ||
                    (sh_q == pasrm_pkg::PTR_NV_HIGH);
   assign is_cmd  = (sh_q == pasrm_pkg::CMD_TO_ACTIVE) || (sh_q == pasrm_pkg::CMD_TO_STORED);

   always_comb begin
      unique case (ptr_q)
         pasrm_pkg::PTR_CFG:     rd_mux = cfg_q;
         pasrm_pkg::PTR_LOW:     rd_mux = low_q;
         pasrm_pkg::PTR_HIGH:    rd_mux = high_q;
         pasrm_pkg::PTR_NV_CFG:  rd_mux = nv_cfg_q;
         pasrm_pkg::PTR_NV_LOW:  rd_mux = nv_low_q;
         pasrm_pkg::PTR_NV_HIGH: rd_mux = nv_high_q;
         default:                rd_mux = temp_q;
      endcase
   end

   always_comb begin
      state_d = state_q;   nxt_d   = nxt_q;    ptr_d   = ptr_q;
      sh_d    = sh_q;      code_d  = code_q;   temp_d  = temp_q;
      cfg_d   = cfg_q;     low_d   = low_q;    high_d  = high_q;
      nv_cfg_d = nv_cfg_q; nv_low_d = nv_low_q; nv_high_d = nv_high_q;
      rd_d    = rd_q;      cnt_d   = cnt_q;    wcnt_d  = wcnt_q;
      oe_n_d  = oe_n_q;    sel_d   = sel_q;    wok_d   = wok_q;
      mnack_d = mnack_q;   conv_d  = 1'b0;     cmd_d   = 1'b0;
      ack     = 1'b0;
      tx      = sel_q ? rd_q[7:0] : rd_q[15:8];
      if (SOFT_RST_IN) begin
         cfg_d   = nv_cfg_q;
         low_d   = nv_low_q;
         high_d  = nv_high_q;
         ptr_d   = pasrm_pkg::PTR_TEMP;
         temp_d  = pasrm_pkg::TEMP_RST;
         conv_d  = 1'b1;
         state_d = pasrm_pkg::ST_IDLE;
         oe_n_d  = 1'b1;
      end else begin
         // Converter results that arrive while a read is shifting out are dropped
         if (TEMP_VALID_IN && !reading) begin
            temp_d = TEMP_DATA_IN;
         end
         if (bus_stop) begin
            state_d = pasrm_pkg::ST_IDLE;
            oe_n_d  = 1'b1;
         end else if (bus_start) begin
            state_d = pasrm_pkg::ST_ADDR;
            cnt_d   = '0;
            oe_n_d  = 1'b1;
         end else begin
            unique case (state_q)
               pasrm_pkg::ST_IDLE, pasrm_pkg::ST_SKIP: begin
               end
               pasrm_pkg::ST_ADDR, pasrm_pkg::ST_PTR, pasrm_pkg::ST_WDAT: begin
                  if (scl_rise) begin
                     sh_d  = {sh_q[6:0], sda_now};
                     cnt_d = cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == pasrm_pkg::BITS_PER_BYTE) begin
                     cnt_d   = '0;
                     state_d = pasrm_pkg::ST_ACK;
                     if (state_q == pasrm_pkg::ST_ADDR) begin
                        nxt_d = pasrm_pkg::ST_SKIP;
                        if (sh_q[7:1] == {pasrm_pkg::DEV_PREFIX, strap}) begin
                           ack = 1'b1;
                           if (sh_q[0]) begin
                              nxt_d = pasrm_pkg::ST_RDAT;
                              rd_d  = rd_mux;
                              sel_d = 1'b0;
                           end else begin
                              nxt_d = pasrm_pkg::ST_PTR;
                           end
                        end
                     end else if (state_q == pasrm_pkg::ST_PTR) begin
                        nxt_d  = pasrm_pkg::ST_WDAT;
                        wcnt_d = '0;
                        wok_d  = 1'b0;
                        if (ptr_ok) begin
                           ack   = 1'b1;
                           ptr_d = sh_q;
                           wok_d = (sh_q != pasrm_pkg::PTR_TEMP);
                        end else if (is_cmd) begin
                           ack    = 1'b1;
                           cmd_d  = 1'b1;
                           code_d = sh_q;
                        end
                        // Anything else is refused and the pointer stays
                     end else begin
                        nxt_d = pasrm_pkg::ST_WDAT;
                        if (wok_q && !REG_LOCK_IN && wcnt_q < pasrm_pkg::DATA_BYTES) begin
                           ack    = 1'b1;
                           wcnt_d = wcnt_q + 2'h1;
                           // Upper byte lands alone, so 8-bit access works
                           unique case (ptr_q)
                              pasrm_pkg::PTR_CFG:
                                 if (wcnt_q == '0) cfg_d[15:8] = sh_q; else cfg_d[7:0] = sh_q;
                              pasrm_pkg::PTR_LOW:
                                 if (wcnt_q == '0) low_d[15:8] = sh_q; else low_d[7:0] = sh_q;
                              pasrm_pkg::PTR_HIGH:
                                 if (wcnt_q == '0) high_d[15:8] = sh_q; else high_d[7:0] = sh_q;
                              pasrm_pkg::PTR_NV_CFG:
                                 if (wcnt_q == '0) nv_cfg_d[15:8] = sh_q; else nv_cfg_d[7:0] = sh_q;
                              pasrm_pkg::PTR_NV_LOW:
                                 if (wcnt_q == '0) nv_low_d[15:8] = sh_q; else nv_low_d[7:0] = sh_q;
                              default:
                                 if (wcnt_q == '0) nv_high_d[15:8] = sh_q; else nv_high_d[7:0] = sh_q;
                           endcase
                        end
                     end
                     oe_n_d = ~ack;
                  end
               end
               pasrm_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     state_d = nxt_q;
                     oe_n_d  = 1'b1;
                     if (nxt_q == pasrm_pkg::ST_RDAT) begin
                        sh_d   = tx;
                        oe_n_d = tx[7];
                        cnt_d  = '0;
                     end
                  end
               end
               pasrm_pkg::ST_RDAT: begin
                  if (scl_fall) begin
                     if (cnt_q == pasrm_pkg::LAST_TX_BIT) begin
                        state_d = pasrm_pkg::ST_MACK;
                        oe_n_d  = 1'b1;
                     end else begin
                        sh_d   = {sh_q[6:0], 1'b0};
                        cnt_d  = cnt_q + 4'h1;
                        oe_n_d = sh_q[6];
                     end
                  end
               end
               pasrm_pkg::ST_MACK: begin
                  if (scl_rise) begin
                     mnack_d = sda_now;
                  end else if (scl_fall) begin
                     if (mnack_q) begin
                        state_d = pasrm_pkg::ST_SKIP;
                     end else begin
                        // After the low byte the same register restarts with fresh data
                        sel_d   = ~sel_q;
                        tx      = sel_q ? rd_mux[15:8] : rd_q[7:0];
                        if (sel_q) begin
                           rd_d = rd_mux;
                        end
                        sh_d    = tx;
                        oe_n_d  = tx[7];
                        cnt_d   = '0;
                        state_d = pasrm_pkg::ST_RDAT;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_q   <= pasrm_pkg::ST_IDLE;
         nxt_q     <= pasrm_pkg::ST_IDLE;
         ptr_q     <= pasrm_pkg::PTR_TEMP;
         sh_q      <= '0;
         code_q    <= '0;
         temp_q    <= pasrm_pkg::TEMP_RST;
         nv_cfg_q  <= pasrm_pkg::FACT_CFG;
         nv_low_q  <= pasrm_pkg::FACT_LOW;
         nv_high_q <= pasrm_pkg::FACT_HIGH;
         cfg_q     <= pasrm_pkg::FACT_CFG;
         low_q     <= pasrm_pkg::FACT_LOW;
         high_q    <= pasrm_pkg::FACT_HIGH;
         rd_q      <= '0;
         cnt_q     <= '0;
         wcnt_q    <= '0;
         oe_n_q    <= 1'b1;
         sel_q     <= 1'b0;
         wok_q     <= 1'b0;
         mnack_q   <= 1'b1;
         conv_q    <= 1'b1;
         cmd_q     <= 1'b0;
      end else begin
         state_q   <= state_d;
         nxt_q     <= nxt_d;
         ptr_q     <= ptr_d;
         sh_q      <= sh_d;
         code_q    <= code_d;
         temp_q    <= temp_d;
         nv_cfg_q  <= nv_cfg_d;
         nv_low_q  <= nv_low_d;
         nv_high_q <= nv_high_d;
         cfg_q     <= cfg_d;
         low_q     <= low_d;
         high_q    <= high_d;
         rd_q      <= rd_d;
         cnt_q     <= cnt_d;
         wcnt_q    <= wcnt_d;
         oe_n_q    <= oe_n_d;
         sel_q     <= sel_d;
         wok_q     <= wok_d;
         mnack_q   <= mnack_d;
         conv_q    <= conv_d;
         cmd_q     <= cmd_d;
      end
   end

   // Sensor logic is fed from the active copies only
   assign CONFIG_OUT     = cfg_q;
   assign LOW_LIMIT_OUT  = low_q;
   assign HIGH_LIMIT_OUT = high_q;
   assign SDA_OUT        = 1'b0;
   assign SDA_OE_N_OUT   = oe_n_q;
   assign CONV_START_OUT = conv_q;
   assign CMD_STROBE_OUT = cmd_q;
   assign CMD_CODE_OUT   = code_q;

   // ***********************************
   // Assertions
   // ***********************************
   a_ptr_after_reset: assert property (@(posedge CLK_IN) $rose(RST_N_IN) |-> ptr_q == pasrm_pkg::PTR_TEMP)
      else $error("pointer not at temperature after reset");
   a_conv_one_pulse: assert property (@(posedge CLK_IN) $rose(RST_N_IN) |-> CONV_START_OUT ##1 !CONV_START_OUT)
      else $error("conversion start not a single pulse after reset");
   a_soft_copy: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      SOFT_RST_IN |=> CONFIG_OUT == $past(nv_cfg_q) && HIGH_LIMIT_OUT == $past(nv_high_q))
      else $error("active copies not loaded from stored copies");
   a_ptr_only_by_ptr: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      $changed(ptr_q) |-> $past(state_q) == pasrm_pkg::ST_PTR || $past(SOFT_RST_IN))
      else $error("pointer changed outside a pointer byte");
   a_bad_ptr_nack: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || SOFT_RST_IN)
      state_q == pasrm_pkg::ST_PTR && scl_fall && cnt_q == pasrm_pkg::BITS_PER_BYTE && !ptr_ok && !is_cmd &&
      !bus_stop && !bus_start
      |=> SDA_OE_N_OUT && $stable(ptr_q) && state_q == pasrm_pkg::ST_ACK)
      else $error("invalid pointer byte was acknowledged or stored");
   a_data_only_wdat: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      $changed(cfg_q) || $changed(nv_low_q) |-> $past(state_q) == pasrm_pkg::ST_WDAT || $past(SOFT_RST_IN))
      else $error("data register changed outside a data byte");
   a_lock_holds: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      REG_LOCK_IN && !SOFT_RST_IN |=> $stable(low_q) && $stable(nv_cfg_q) && $stable(nv_high_q))
      else $error("register written while locked");
   a_temp_from_conv: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      $changed(temp_q) |-> $past(TEMP_VALID_IN) || $past(SOFT_RST_IN))
      else $error("temperature changed without a conversion");
   a_cmd_upper_bits: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      CMD_STROBE_OUT |-> CMD_CODE_OUT[7:5] != 3'h0 ##1 !CMD_STROBE_OUT)
      else $error("command strobe malformed");
   a_foreign_addr: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || SOFT_RST_IN)
      state_q == pasrm_pkg::ST_ADDR && scl_fall && cnt_q == pasrm_pkg::BITS_PER_BYTE && !bus_stop && !bus_start &&
      sh_q[7:1] != {pasrm_pkg::DEV_PREFIX, strap} |=> nxt_q == pasrm_pkg::ST_SKIP && SDA_OE_N_OUT)
      else $error("foreign address acknowledged");
endmodule
`default_nettype wire

//--- verif/pasrm_bus_master.sv
/*
 Two-wire bus master model for the sensor register map: start, stop and byte tasks.
 Assumes an open-drain data wire with a pull-up, and a free-running CLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module pasrm_bus_master (
   input  wire logic CLK_IN,
   input  wire logic SDA_OE_N_IN,
   output logic      SCL_OUT,
   output logic      SDA_OUT
);
   // ***********************************
   // Wire levels
   // ***********************************
   logic scl_q;
   logic sda_q;
   initial begin
      scl_q = 1'b1;
      sda_q = 1'b1;
   end
   assign SCL_OUT = scl_q;
   // Pull-up: the wire is low while either party pulls it
   assign SDA_OUT = sda_q & SDA_OE_N_IN;
   // ***********************************
   // Bus tasks
   // ***********************************
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_IN);
      #1;
   endtask
   // Also serves as repeated start when the clock is low
   task automatic start_cond();
      sda_q = 1'b1;
      tick(8);
      scl_q = 1'b1;
      tick(8);
      sda_q = 1'b0;
      tick(8);
      scl_q = 1'b0;
      tick(8);
   endtask
   task automatic stop_cond();
      sda_q = 1'b0;
      tick(8);
      scl_q = 1'b1;
      tick(8);
      sda_q = 1'b1;
      tick(8);
   endtask
   // Data held 8 clocks either side of each clock edge
   task automatic clock_bit(input logic b, output logic seen);
      sda_q = b;
      tick(8);
      scl_q = 1'b1;
      tick(8);
      seen = SDA_OUT;
      scl_q = 1'b0;
      tick(8);
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(d[i], s);
      end
      clock_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         d[i] = s;
      end
      clock_bit(~ack, s);
   endtask
endmodule
`default_nettype wire

//--- verif/tb_pointer_addressed_sensor_register_map.sv
/*
 Self-checking testbench for the sensor register map, driven through the bus master model.
 Assumes the design and the master model are compiled first; one 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pointer_addressed_sensor_register_map;
   localparam logic [2:0] STRAP = 3'h5;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        soft_rst = 1'b0;
   logic        lock = 1'b0;
   logic [15:0] temp_data = 16'h0000;
   logic        temp_valid = 1'b0;
   logic        scl;
   logic        sda;
   logic        oe_n;
   logic [15:0] cfg;
   logic [15:0] low;
   logic [15:0] high;
   logic        conv;
   logic        cmd_stb;
   logic [7:0]  cmd_code;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          n_cmd = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (cmd_stb === 1'b1) n_cmd++;
   pasrm_regmap u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SOFT_RST_IN(soft_rst), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(), .SDA_OE_N_OUT(oe_n), .ADDR_STRAP_IN(STRAP), .REG_LOCK_IN(lock), .TEMP_DATA_IN(temp_data),
      .TEMP_VALID_IN(temp_valid), .CONFIG_OUT(cfg), .LOW_LIMIT_OUT(low), .HIGH_LIMIT_OUT(high),
      .CONV_START_OUT(conv), .CMD_STROBE_OUT(cmd_stb), .CMD_CODE_OUT(cmd_code));
   pasrm_bus_master u_master (.CLK_IN(clk), .SDA_OE_N_IN(oe_n), .SCL_OUT(scl), .SDA_OUT(sda));
   // ***********************************
   // Helpers
   // ***********************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Acks: bit 3 address, bit 2 pointer, bits 1:0 data bytes; 1 means acknowledged
   task automatic wr(input logic [7:0] ptr, input int nb, input logic [15:0] d, output logic [3:0] ak);
      ak = 4'h0;
      u_master.start_cond();
      u_master.put_byte({pasrm_pkg::DEV_PREFIX, STRAP, 1'b0}, ak[3]);
      u_master.put_byte(ptr, ak[2]);
      if (nb > 0) u_master.put_byte(d[15:8], ak[1]);
      if (nb > 1) u_master.put_byte(d[7:0], ak[0]);
      u_master.stop_cond();
   endtask
   task automatic rd_chk(input string what, input logic [15:0] exp);
      logic       a;
      logic [15:0] d;
      u_master.start_cond();
      u_master.put_byte({pasrm_pkg::DEV_PREFIX, STRAP, 1'b1}, a);
      u_master.get_byte(1'b1, d[15:8]);
      u_master.get_byte(1'b0, d[7:0]);
      u_master.stop_cond();
      cmp_val(what, exp, d);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_reset();
      tick(8);
      cmp_bit("conv start", 1'b1, conv);
      rst_n = 1'b1;
      tick(8);
      cmp_val("config", pasrm_pkg::FACT_CFG, cfg);
      cmp_val("low", pasrm_pkg::FACT_LOW, low);
      cmp_val("high", pasrm_pkg::FACT_HIGH, high);
      rd_chk("temp at reset", pasrm_pkg::TEMP_RST);
   endtask
   task automatic t_temp();
      logic [3:0] ak;
      temp_data = 16'h1940;
      temp_valid = 1'b1;
      tick(1);
      temp_valid = 1'b0;
      tick(2);
      rd_chk("temp", 16'h1940);
      rd_chk("temp again", 16'h1940);
      wr(pasrm_pkg::PTR_TEMP, 2, 16'hffff, ak);
      cmp_bit("temp data ack", 1'b0, ak[1]);
      rd_chk("temp kept", 16'h1940);
   endtask
   task automatic t_regs();
      logic [7:0]  p [6] = '{pasrm_pkg::PTR_CFG, pasrm_pkg::PTR_LOW, pasrm_pkg::PTR_HIGH,
                             pasrm_pkg::PTR_NV_CFG, pasrm_pkg::PTR_NV_LOW, pasrm_pkg::PTR_NV_HIGH};
      logic [15:0] v [6] = '{16'h6080, 16'h1900, 16'h2d00, 16'h0060, 16'h0a00, 16'h3c00};
      logic [3:0]  ak;
      for (int i = 0; i < 6; i++) begin
         wr(p[i], 2, v[i], ak);
         cmp_bit("address ack", 1'b1, ak[3]);
         cmp_bit("pointer ack", 1'b1, ak[2]);
         cmp_bit("data ack", 1'b1, ak[0]);
         rd_chk("readback", v[i]);
      end
      cmp_val("config", v[0], cfg);
      cmp_val("low", v[1], low);
      cmp_val("high", v[2], high);
      wr(pasrm_pkg::PTR_CFG, 1, 16'h5a00, ak);
      cmp_val("config upper", 16'h5a80, cfg);
      wr(pasrm_pkg::PTR_LOW, 0, 16'h0000, ak);
      cmp_val("low kept", v[1], low);
      rd_chk("pointer only", v[1]);
   endtask
   task automatic t_refuse();
      logic [3:0] ak;
      wr(8'h05, 1, 16'h7700, ak);
      cmp_bit("bad pointer ack", 1'b0, ak[2]);
      rd_chk("pointer kept", 16'h1900);
      for (int i = 0; i < 2; i++) begin
         wr(i ? pasrm_pkg::CMD_TO_STORED : pasrm_pkg::CMD_TO_ACTIVE, 1, 16'h0100, ak);
         cmp_bit("command ack", 1'b1, ak[2]);
         cmp_bit("command data ack", 1'b0, ak[1]);
         cmp_val("command code", {8'h00, i ? pasrm_pkg::CMD_TO_STORED : pasrm_pkg::CMD_TO_ACTIVE},
                 {8'h00, cmd_code});
         cmp_val("command strobes", 16'(i + 1), 16'(n_cmd));
      end
      lock = 1'b1;
      wr(pasrm_pkg::PTR_HIGH, 2, 16'h1111, ak);
      lock = 1'b0;
      cmp_bit("locked ack", 1'b0, ak[1]);
      cmp_val("high locked", 16'h2d00, high);
      u_master.start_cond();
      u_master.put_byte({pasrm_pkg::DEV_PREFIX, STRAP ^ 3'h1, 1'b0}, ak[3]);
      u_master.stop_cond();
      cmp_bit("foreign address ack", 1'b0, ak[3]);
   endtask
   task automatic t_soft();
      logic [3:0] ak;
      soft_rst = 1'b1;
      tick(1);
      soft_rst = 1'b0;
      cmp_bit("soft conv start", 1'b1, conv);
      cmp_val("config copy", 16'h0060, cfg);
      cmp_val("low copy", 16'h0a00, low);
      cmp_val("high copy", 16'h3c00, high);
      tick(1);
      cmp_bit("conv pulse end", 1'b0, conv);
      tick(8);
      rd_chk("temp after soft reset", pasrm_pkg::TEMP_RST);
      wr(pasrm_pkg::PTR_NV_CFG, 0, 16'h0000, ak);
      rd_chk("stored kept", 16'h0060);
   endtask
   initial begin
      t_reset();
      t_temp();
      t_regs();
      t_refuse();
      t_soft();
      results();
   end
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      results();
   end
endmodule
`default_nettype wire
